// >>> design/gtp_protect.sv
/*
 * Generator trip protection: latching trips and shutdowns, high current
 * warning and inverse_time_curve accumulators, and the shed/cool/stop order.
 * Assumes measurements and config are on core_clk_i; aux and stop/reset
 * arrive from pins. Curve bases for earth fault and short circuit
 * (0.14/((I/Is)^0.02-1), in ms) come from the measurement front end.
 */
// Functional notes
// RL1: trip drops close, cools, then stops engine
// RL2: alarms latch until fault gone and reset
// RL3: high current warns, escalates after long overload
// RL4: aux trip input raises trip, selects message
// RL5: total kW above limit raises trip
// RL6: earth current above setting raises trip
// RL7: fuel usage above limit raises trip
// RL8: loading voltage missed at safety end: shutdown
// RL9: loading frequency missed at safety end: shutdown
// RL10: protections disabled: indicate, log, keep running
// RL11: frequency below limit raises trip
// RL12: voltage below limit raises trip
// RL13: incompatible link module raises compatibility trip
// RL14: speed below limit raises underspeed trip
// RL15: immediate warning at trip level, self clears
// RL16: inverse time expiry raises configured action
// RL17: overcurrent delay is t over squared excess
// RL18: accumulator cools so repeat overload trips sooner
// RL19: earth fault inverse time gives configured action
// RL20: short circuit uses same formula, smaller multiplier
// RL21: delay is K times curve base
// RL22: earth fault multiplier defaults to 0.4
// RL23: accumulators step once per measurement period
`timescale 1ns/1ps
module gtp_protect #(
    parameter int PERIOD_CYC = gtp_pkg::PERIOD_CYC,
    parameter int COOL_TICKS = gtp_pkg::COOL_TICKS,
    parameter int NAUX       = 4,
    parameter int EF_K       = gtp_pkg::EF_K_MILLI,
    parameter int SC_K       = gtp_pkg::SC_K_MILLI
) (
    input  wire logic                 core_clk_i,       // core clock
    input  wire logic                 rst_b_i,          // sync reset, low
    input  wire gtp_pkg::gtp_meas_t   meas_i,           // measurements
    input  wire gtp_pkg::gtp_cfg_t    cfg_i,            // configuration
    input  wire logic                 running_i,        // engine running
    input  wire logic                 safety_done_i,    // safety timer over
    input  wire logic                 link_incompat_i,  // bad link module
    input  wire logic                 close_req_i,      // close wanted
    input  wire logic                 stop_reset_pin_i, // stop/reset pin
    input  wire logic [NAUX-1:0]      aux_pin_i,        // aux input pins
    input  wire logic [NAUX-1:0]      aux_trip_cfg_i,   // aux is a trip
    output logic                      gen_close_o,      // close generator
    output logic                      cool_run_o,       // cooling timer on
    output logic                      engine_stop_o,    // stop engine
    output logic [$clog2(NAUX)-1:0]   aux_msg_o,        // aux message index
    output logic                      aux_msg_vld_o,    // aux message valid
    output logic                      log_evt_o,        // log event pulse
    output gtp_pkg::gtp_stat_t        stat_o            // alarm status
);
    localparam int DW = $clog2(PERIOD_CYC);
    localparam int CW = $clog2(COOL_TICKS + 1);
    localparam int AW = $clog2(NAUX);

    typedef struct packed {
        logic [NAUX:0]        s1, s2, s3, filt;
        logic [DW-1:0]        div;
        logic                 tick;
        logic [47:0]          oc_acc;
        logic [31:0]          ef_acc, sc_acc;
        logic [gtp_pkg::TR_N-1:0] tr;
        logic [gtp_pkg::SD_N-1:0] sd;
        logic                 warn;
        gtp_pkg::gtp_seq_t    seq;
        logic [CW-1:0]        cool;
        logic                 close, stop, log;
        logic [AW-1:0]        msg;
        logic                 msg_vld;
    } gtp_state_t;

    gtp_state_t st;
    gtp_state_t next_st;

    logic [15:0]               imax;
    logic [15:0]               excess;
    logic [31:0]               sq;
    logic [47:0]               oc_thr;
    logic                      oc_over, oc_reach, oc_exp;
    logic [31:0]               ef_thr, sc_thr;
    logic                      ef_over, sc_over, ef_exp, sc_exp;
    logic [gtp_pkg::TR_N-1:0]  tr_set, tr_pres;
    logic [gtp_pkg::SD_N-1:0]  sd_set, sd_pres;
    logic [NAUX-1:0]           aux_hit;
    logic [AW-1:0]             aux_idx;
    logic                      clr, trip_act, shut_act;

    // earth fault / short circuit step: reset when healthy, hold at expiry
    function automatic logic [31:0] gtp_step(input logic [31:0] acc,
                                             input logic run, input logic done);
        if (!run)
            return 32'h0000_0000;
        if (done)
            return acc;
        return acc + 32'(gtp_pkg::EF_STEP); // RL21
    endfunction

    assign imax = (meas_i.ph_a >= meas_i.ph_b && meas_i.ph_a >= meas_i.ph_c) ? meas_i.ph_a :
                  (meas_i.ph_b >= meas_i.ph_c) ? meas_i.ph_b : meas_i.ph_c;
    assign oc_over  = imax > cfg_i.oc_trip;
    assign oc_reach = imax >= cfg_i.oc_trip;
    assign excess   = imax - cfg_i.oc_trip;
    assign sq       = 32'(excess) * 32'(excess);
    // trip when sum of squared excess reaches t*It^2: T = t/(Ia/It-1)^2
    assign oc_thr   = 48'(cfg_i.oc_mult) * 48'(cfg_i.oc_trip) * 48'(cfg_i.oc_trip); // RL17
    assign oc_exp   = st.oc_acc >= oc_thr;
    assign ef_over  = meas_i.earth > cfg_i.ef_set;
    assign sc_over  = imax > cfg_i.sc_set;
    assign ef_thr   = 32'(EF_K) * 32'(meas_i.ef_curve); // RL22
    assign sc_thr   = 32'(SC_K) * 32'(meas_i.sc_curve); // RL20
    assign ef_exp   = st.ef_acc >= ef_thr;
    assign sc_exp   = st.sc_acc >= sc_thr;
    assign aux_hit  = st.filt[NAUX-1:0] & aux_trip_cfg_i;
    assign clr      = st.filt[NAUX];
    assign trip_act = (|st.tr) & ~cfg_i.prot_dis;
    assign shut_act = (|st.sd) & ~cfg_i.prot_dis;

    always_comb begin
        aux_idx = '0;
        for (int i = NAUX - 1; i >= 0; i--) begin
            if (aux_hit[i]) begin
                aux_idx = AW'(i);
            end
        end
    end

    always_comb begin
        tr_set = '0;
        sd_set = '0;
        tr_set[gtp_pkg::TR_HC]   = cfg_i.curve_en & cfg_i.hc_trip & oc_exp; // RL16
        tr_set[gtp_pkg::TR_AUX]  = |aux_hit; // RL4
        tr_set[gtp_pkg::TR_KW]   = meas_i.kw > cfg_i.kw_lim; // RL5
        tr_set[gtp_pkg::TR_EF]   = cfg_i.ef_en & cfg_i.ef_trip & ef_exp; // RL6
        tr_set[gtp_pkg::TR_FUEL] = meas_i.fuel > cfg_i.fuel_lim; // RL7
        tr_set[gtp_pkg::TR_UF]   = running_i & (meas_i.freq < cfg_i.uf_lim); // RL11
        tr_set[gtp_pkg::TR_UV]   = running_i & (meas_i.volt < cfg_i.uv_lim); // RL12
        tr_set[gtp_pkg::TR_LINK] = link_incompat_i; // RL13
        tr_set[gtp_pkg::TR_USPD] = running_i & (meas_i.speed < cfg_i.us_lim); // RL14
        tr_set[gtp_pkg::TR_SC]   = cfg_i.sc_en & cfg_i.sc_trip & sc_exp;
        sd_set[gtp_pkg::SD_HC]   = cfg_i.curve_en & ~cfg_i.hc_trip & oc_exp; // RL3
        sd_set[gtp_pkg::SD_EF]   = cfg_i.ef_en & ~cfg_i.ef_trip & ef_exp; // RL19
        sd_set[gtp_pkg::SD_SC]   = cfg_i.sc_en & ~cfg_i.sc_trip & sc_exp;
        sd_set[gtp_pkg::SD_LDV]  = safety_done_i & (meas_i.volt <= cfg_i.load_volt); // RL8
        sd_set[gtp_pkg::SD_LDF]  = safety_done_i & (meas_i.freq <= cfg_i.load_freq); // RL9
        // inverse-time alarms count as present while the current is over
        tr_pres = tr_set;
        sd_pres = sd_set;
        tr_pres[gtp_pkg::TR_HC] = oc_over;
        tr_pres[gtp_pkg::TR_EF] = ef_over;
        tr_pres[gtp_pkg::TR_SC] = sc_over;
        sd_pres[gtp_pkg::SD_HC] = oc_over;
        sd_pres[gtp_pkg::SD_EF] = ef_over;
        sd_pres[gtp_pkg::SD_SC] = sc_over;
    end

    always_comb begin
        next_st = st;
        next_st.s1 = {stop_reset_pin_i, aux_pin_i};
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.filt = (st.s2 & ~(st.s2 ^ st.s3)) | (st.filt & (st.s2 ^ st.s3));

        next_st.tick = 1'b0;
        if (st.div == DW'(PERIOD_CYC - 1)) begin
            next_st.div  = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.div = st.div + 1'b1;
        end

        if (st.tick) begin // RL23
            if (cfg_i.curve_en && oc_over) begin
                if (!oc_exp) begin
                    next_st.oc_acc = st.oc_acc + 48'(sq); // RL16
                end
            end else if (st.oc_acc != 48'h0) begin
                // exponential decay keeps heat from a recent overload
                next_st.oc_acc = st.oc_acc - (st.oc_acc >> gtp_pkg::OC_COOL_SH)
                                 - 48'h1; // RL18
            end
            next_st.ef_acc = gtp_step(st.ef_acc, cfg_i.ef_en & ef_over, ef_exp); // RL19
            next_st.sc_acc = gtp_step(st.sc_acc, cfg_i.sc_en & sc_over, sc_exp); // RL20
        end

        // set wins over a reset in the same cycle
        next_st.tr = tr_set | (st.tr & ~({gtp_pkg::TR_N{clr}} & ~tr_pres)); // RL2
        next_st.sd = sd_set | (st.sd & ~({gtp_pkg::SD_N{clr}} & ~sd_pres)); // RL2
        next_st.log = cfg_i.prot_dis &
                      (|((tr_set & ~st.tr) | (sd_set & ~st.sd))); // RL10
        next_st.warn = cfg_i.imm_warn_en &
                       (oc_reach | (cfg_i.latch_warn & st.warn & ~clr)); // RL15

        if (|aux_hit) begin
            next_st.msg = aux_idx; // RL4
        end
        next_st.msg_vld = |aux_hit;

        unique case (st.seq)
            gtp_pkg::SEQ_IDLE: begin
                if (trip_act) begin
                    next_st.seq = gtp_pkg::SEQ_SHED; // RL1
                end
            end
            gtp_pkg::SEQ_SHED: begin
                next_st.seq  = gtp_pkg::SEQ_COOL;
                next_st.cool = '0;
            end
            gtp_pkg::SEQ_COOL: begin
                if (!trip_act) begin
                    next_st.seq = gtp_pkg::SEQ_IDLE;
                end else if (st.tick) begin
                    if (st.cool == CW'(COOL_TICKS - 1)) begin
                        next_st.seq = gtp_pkg::SEQ_STOP; // RL1
                    end else begin
                        next_st.cool = st.cool + 1'b1;
                    end
                end
            end
            gtp_pkg::SEQ_STOP: begin
                if (!trip_act) begin
                    next_st.seq = gtp_pkg::SEQ_IDLE;
                end
            end
        endcase

        next_st.stop  = shut_act | (next_st.seq == gtp_pkg::SEQ_STOP); // RL1
        next_st.close = close_req_i & ~shut_act &
                        (next_st.seq == gtp_pkg::SEQ_IDLE); // RL1
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign gen_close_o         = st.close;
    assign cool_run_o          = st.seq == gtp_pkg::SEQ_COOL;
    assign engine_stop_o       = st.stop;
    assign aux_msg_o           = st.msg;
    assign aux_msg_vld_o       = st.msg_vld;
    assign log_evt_o           = st.log;
    assign stat_o.trip_lat     = st.tr;
    assign stat_o.shut_lat     = st.sd;
    assign stat_o.hc_warn      = st.warn;
    assign stat_o.prot_dis_ind = cfg_i.prot_dis;

    default clocking gtp_cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    chk_close_shed: assert property ( // RL1
        trip_act |=> !gen_close_o)
        else $error("close held during trip sequence");
    chk_stop_after_cool: assert property ( // RL1
        st.seq == gtp_pkg::SEQ_COOL && !shut_act |-> !engine_stop_o)
        else $error("engine stopped before cooling ended");
    chk_latch_hold: assert property ( // RL2
        !clr |=> ($past(st.tr) & ~st.tr) == '0)
        else $error("trip latch dropped without reset");
    chk_kw_trip: assert property ( // RL5
        meas_i.kw > cfg_i.kw_lim |=> stat_o.trip_lat[gtp_pkg::TR_KW])
        else $error("kw overload not latched");
    chk_uv_trip: assert property ( // RL12
        running_i && meas_i.volt < cfg_i.uv_lim |=> stat_o.trip_lat[gtp_pkg::TR_UV])
        else $error("under voltage not latched");
    chk_ldv_shut: assert property ( // RL8
        safety_done_i && meas_i.volt <= cfg_i.load_volt
        |=> stat_o.shut_lat[gtp_pkg::SD_LDV] ##1 engine_stop_o || cfg_i.prot_dis)
        else $error("loading voltage shutdown missing");
    chk_dis_run: assert property ( // RL10
        cfg_i.prot_dis && $past(cfg_i.prot_dis) |-> !engine_stop_o)
        else $error("engine stopped with protections disabled");
    chk_warn_clear: assert property ( // RL15
        cfg_i.imm_warn_en && !cfg_i.latch_warn && !oc_reach |=> !stat_o.hc_warn)
        else $error("warning did not self clear");
    chk_oc_expiry: assert property ( // RL16
        cfg_i.curve_en && cfg_i.hc_trip && oc_exp |=> stat_o.trip_lat[gtp_pkg::TR_HC])
        else $error("overcurrent expiry not latched");
    chk_cool_decay: assert property ( // RL18
        st.tick && !oc_over && st.oc_acc != 48'h0 |=> st.oc_acc < $past(st.oc_acc))
        else $error("overload state did not cool");
    chk_aux_msg: assert property ( // RL4
        |aux_hit |=> stat_o.trip_lat[gtp_pkg::TR_AUX] && aux_msg_vld_o)
        else $error("aux trip or message missing");

    cov_full_stop: cover property (
        st.seq == gtp_pkg::SEQ_COOL ##1 st.seq == gtp_pkg::SEQ_STOP);
    cov_hc_warn: cover property ($rose(stat_o.hc_warn));
    cov_ef_trip: cover property ($rose(stat_o.trip_lat[gtp_pkg::TR_EF]));
    cov_dis_log: cover property (log_evt_o);
endmodule

// >>> inc/gtp_pkg.sv
/*
 * Shared constants and carrier types for the generator trip protection block.
 * Assumes measurement front ends deliver scaled 16-bit values on the core clock.
 */
package gtp_pkg;
    localparam int CLK_HZ     = 25_000_000;
    localparam int PERIOD_MS  = 10;
    localparam int PERIOD_CYC = CLK_HZ / 1000 * PERIOD_MS;
    localparam int COOL_S     = 60;
    localparam int COOL_TICKS = COOL_S * 1000 / PERIOD_MS;
    // earth fault and short circuit time multipliers are held in thousandths
    localparam int K_SCALE    = 1000;
    localparam int EF_K_MILLI = 400;
    localparam int SC_K_MILLI = 10;
    localparam int EF_STEP    = PERIOD_MS * K_SCALE;
    localparam int OC_COOL_SH = 6;

    localparam int TR_HC   = 0;
    localparam int TR_AUX  = 1;
    localparam int TR_KW   = 2;
    localparam int TR_EF   = 3;
    localparam int TR_FUEL = 4;
    localparam int TR_UF   = 5;
    localparam int TR_UV   = 6;
    localparam int TR_LINK = 7;
    localparam int TR_USPD = 8;
    localparam int TR_SC   = 9;
    localparam int TR_N    = 10;

    localparam int SD_HC  = 0;
    localparam int SD_EF  = 1;
    localparam int SD_SC  = 2;
    localparam int SD_LDV = 3;
    localparam int SD_LDF = 4;
    localparam int SD_N   = 5;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SHED, SEQ_COOL, SEQ_STOP} gtp_seq_t;

    typedef struct packed {
        logic [15:0] ph_a, ph_b, ph_c, earth, kw, volt, freq, speed, fuel;
        logic [15:0] ef_curve, sc_curve;
    } gtp_meas_t;

    typedef struct packed {
        logic [15:0] oc_trip, oc_mult, ef_set, sc_set, kw_lim, fuel_lim;
        logic [15:0] load_volt, load_freq, uv_lim, uf_lim, us_lim;
        logic        imm_warn_en, latch_warn, curve_en, hc_trip;
        logic        ef_en, ef_trip, sc_en, sc_trip, prot_dis;
    } gtp_cfg_t;

    typedef struct packed {
        logic [TR_N-1:0] trip_lat;
        logic [SD_N-1:0] shut_lat;
        logic            hc_warn;
        logic            prot_dis_ind;
    } gtp_stat_t;
endpackage

// >>> verif/gtp_gen_model.sv
/*
 * Far side model for the trip protection block: breaker, engine and sensing.
 * Assumes the bench sets the loaded readings on set_i, on the same core clock.
 */
`timescale 1ns/1ps
module gtp_gen_model (
    input  wire logic               core_clk_i,    // core clock
    input  wire logic               rst_b_i,       // sync reset, low
    input  wire logic               gen_close_i,   // breaker close command
    input  wire logic               engine_stop_i, // engine stop command
    input  wire gtp_pkg::gtp_meas_t set_i,         // readings when loaded and running
    output logic                    running_o,     // engine turning
    output gtp_pkg::gtp_meas_t      meas_o         // readings seen by the block
);
    // the engine restarts as soon as stop is withdrawn; real sets take longer
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            running_o <= 1'b1;
        end else begin
            running_o <= !engine_stop_i;
        end
    end

    // an open breaker carries no load, so load side faults vanish with it
    always_comb begin
        meas_o = set_i;
        if (!gen_close_i) begin
            meas_o.ph_a  = 16'h0000;
            meas_o.ph_b  = 16'h0000;
            meas_o.ph_c  = 16'h0000;
            meas_o.earth = 16'h0000;
            meas_o.kw    = 16'h0000;
        end
        if (!running_o) begin
            meas_o.volt  = 16'h0000;
            meas_o.freq  = 16'h0000;
            meas_o.speed = 16'h0000;
        end
    end
endmodule

// >>> verif/test_gtp_protect.sv
/*
 * Self-checking bench for the trip protection block.
 * Assumes gtp_gen_model as the far side and shortened period and cooling counts.
 */
`timescale 1ns/1ps
module test_gtp_protect;
    localparam int PER  = 8;
    localparam int COOL = 4;
    logic               clk = 1'b0;
    logic               rst_b = 1'b0;
    gtp_pkg::gtp_meas_t meas_set, meas;
    gtp_pkg::gtp_cfg_t  cfg;
    gtp_pkg::gtp_stat_t stat;
    logic               running, safety_done, link_bad, close_req, stop_pin;
    logic [3:0]         aux_pin, aux_cfg;
    logic               gen_close, cool_run, eng_stop, aux_vld, log_evt;
    logic [1:0]         aux_msg;
    int                 error_cnt = 0;
    int                 checked = 0;
    int                 n, t;
    int                 simple[4] = '{gtp_pkg::TR_UF, gtp_pkg::TR_UV, gtp_pkg::TR_LINK,
                                      gtp_pkg::TR_USPD};

    always #20 clk = ~clk;

    gtp_gen_model i_gtp_gen_model (.core_clk_i(clk), .rst_b_i(rst_b), .gen_close_i(gen_close),
        .engine_stop_i(eng_stop), .set_i(meas_set), .running_o(running), .meas_o(meas));

    gtp_protect #(.PERIOD_CYC(PER), .COOL_TICKS(COOL)) i_gtp_protect (
        .core_clk_i(clk), .rst_b_i(rst_b), .meas_i(meas), .cfg_i(cfg), .running_i(running),
        .safety_done_i(safety_done), .link_incompat_i(link_bad), .close_req_i(close_req),
        .stop_reset_pin_i(stop_pin), .aux_pin_i(aux_pin), .aux_trip_cfg_i(aux_cfg),
        .gen_close_o(gen_close), .cool_run_o(cool_run), .engine_stop_o(eng_stop),
        .aux_msg_o(aux_msg), .aux_msg_vld_o(aux_vld), .log_evt_o(log_evt), .stat_o(stat));

    // selector: 0..9 trips, 10..14 shutdowns, 20 up are single outputs
    function automatic logic sig(input int s);
        case (s)
            20: return gen_close;
            21: return cool_run;
            22: return eng_stop;
            23: return stat.hc_warn;
            24: return log_evt;
            default: return (s < 10) ? stat.trip_lat[s] : stat.shut_lat[s-10];
        endcase
    endfunction

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        #1;
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
        end
    endtask

    task automatic chk_rng(input string nm, input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("unexpected %s: expected %0d to %0d cycles, seen %0d", nm, lo, hi, got);
        end
    endtask

    // bounded wait for an output level, then judge how long it took
    task automatic wt(input string nm, input int s, input logic v, input int lo, input int hi);
        n = 0;
        #1;
        while (sig(s) !== v && n <= hi) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_rng(nm, n, lo, hi);
    endtask

    task automatic nominal();
        meas_set <= '{ph_a:16'h0032, ph_b:16'h0032, ph_c:16'h0032, kw:16'h0064, volt:16'h00E6,
            freq:16'h0032, speed:16'h05DC, ef_curve:16'h0064, sc_curve:16'h07D0, default:16'h0000};
        cfg <= '{oc_trip:16'h0064, oc_mult:16'h0004, ef_set:16'h000A, sc_set:16'h012C,
            kw_lim:16'h01F4, fuel_lim:16'h003C, load_volt:16'h00C8, load_freq:16'h002D,
            uv_lim:16'h00B4, uf_lim:16'h0028, us_lim:16'h03E8, default:'0};
        safety_done <= 1'b0;
        link_bad <= 1'b0;
        close_req <= 1'b1;
        stop_pin <= 1'b0;
        aux_pin <= 4'h0;
        aux_cfg <= 4'h0;
    endtask

    task automatic do_reset();
        cyc(1);
        rst_b <= 1'b0;
        nominal();
        cyc(8);
        rst_b <= 1'b1;
        cyc(4);
    endtask

    // the pin passes a three flop filter, so it is held well past that
    task automatic clear();
        cyc(1);
        stop_pin <= 1'b1;
        cyc(8);
        stop_pin <= 1'b0;
        cyc(8);
    endtask

    task automatic set_fault(input int i, input logic on);
        cyc(1);
        case (i)
            gtp_pkg::TR_KW:   meas_set.kw    <= on ? 16'h0258 : 16'h0064;
            gtp_pkg::TR_FUEL: meas_set.fuel  <= on ? 16'h0050 : 16'h0000;
            gtp_pkg::TR_UF:   meas_set.freq  <= on ? 16'h001E : 16'h0032;
            gtp_pkg::TR_UV:   meas_set.volt  <= on ? 16'h0096 : 16'h00E6;
            gtp_pkg::TR_LINK: link_bad       <= on;
            default:          meas_set.speed <= on ? 16'h0384 : 16'h05DC;
        endcase
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        summarize();
    end

    initial begin
        nominal();
        do_reset();
        wt("close follows request", 20, 1'b1, 0, 3);
        set_fault(gtp_pkg::TR_KW, 1'b1);
        wt("kw trip", gtp_pkg::TR_KW, 1'b1, 0, 3);
        wt("load shed", 20, 1'b0, 0, 3);
        chk("stop before cooling", 16'h0000, 16'(eng_stop));
        wt("cooling start", 21, 1'b1, 0, 2);
        wt("cooling span", 22, 1'b1, (COOL-1)*PER, (COOL+1)*PER+4);
        chk("kw latch held", 16'h0001, 16'(stat.trip_lat[gtp_pkg::TR_KW]));
        set_fault(gtp_pkg::TR_KW, 1'b0);
        clear();
        chk("kw latch cleared", 16'h0000, 16'(stat.trip_lat[gtp_pkg::TR_KW]));
        wt("engine released", 22, 1'b0, 0, 3);
        set_fault(gtp_pkg::TR_FUEL, 1'b1);
        wt("fuel trip", gtp_pkg::TR_FUEL, 1'b1, 0, 3);
        clear();
        chk("reset with fault", 16'h0001, 16'(stat.trip_lat[gtp_pkg::TR_FUEL]));
        set_fault(gtp_pkg::TR_FUEL, 1'b0);
        cyc(4);
        chk("fault gone no reset", 16'h0001, 16'(stat.trip_lat[gtp_pkg::TR_FUEL]));
        clear();
        chk("fuel cleared", 16'h0000, 16'(stat.trip_lat[gtp_pkg::TR_FUEL]));
        foreach (simple[k]) begin
            set_fault(simple[k], 1'b1);
            wt($sformatf("trip %0d", simple[k]), simple[k], 1'b1, 0, 3);
            set_fault(simple[k], 1'b0);
            clear();
            chk("trip cleared", 16'h0000, 16'(stat.trip_lat[simple[k]]));
        end
        cyc(1);
        aux_cfg <= 4'h6;
        aux_pin <= 4'hD;
        wt("aux trip", gtp_pkg::TR_AUX, 1'b1, 3, 8);
        chk("aux message", 16'h0002, 16'(aux_msg));
        chk("aux valid", 16'h0001, 16'(aux_vld));
        cyc(1);
        aux_pin <= 4'h1;
        clear();
        chk("aux cleared", 16'h0000, 16'(stat.trip_lat[gtp_pkg::TR_AUX]));
        chk("aux valid off", 16'h0000, 16'(aux_vld));
        for (int k = 0; k < 2; k++) begin
            cyc(1);
            if (k == 0) meas_set.volt <= 16'h00BE;
            else meas_set.freq <= 16'h002C;
            safety_done <= 1'b1;
            wt("loading shutdown", 10 + gtp_pkg::SD_LDV + k, 1'b1, 0, 3);
            wt("loading stop", 22, 1'b1, 0, 3);
            cyc(1);
            safety_done <= 1'b0;
            meas_set.volt <= 16'h00E6;
            meas_set.freq <= 16'h0032;
            clear();
        end
        cyc(1);
        cfg.imm_warn_en <= 1'b1;
        meas_set.ph_b <= 16'h0064;
        wt("warn at trip level", 23, 1'b1, 0, 3);
        cyc(1);
        meas_set.ph_b <= 16'h0063;
        wt("warn self clear", 23, 1'b0, 0, 3);
        cyc(1);
        cfg.latch_warn <= 1'b1;
        meas_set.ph_b <= 16'h0064;
        wt("warn again", 23, 1'b1, 0, 3);
        cyc(1);
        meas_set.ph_b <= 16'h0032;
        cyc(4);
        chk("warn latched", 16'h0001, 16'(stat.hc_warn));
        clear();
        chk("warn reset", 16'h0000, 16'(stat.hc_warn));
        // twice full load: four periods to reach the multiplier
        for (int k = 0; k < 2; k++) begin
            do_reset();
            cfg.curve_en <= 1'b1;
            cfg.imm_warn_en <= 1'b1;
            cfg.hc_trip <= (k == 0);
            meas_set.ph_a <= 16'h00C8;
            wt("overload warning", 23, 1'b1, 0, 3);
            t = n;
            wt("inverse time expiry", (k == 0) ? gtp_pkg::TR_HC : 10 + gtp_pkg::SD_HC, 1'b1,
                3*PER-4-t, 4*PER+3-t);
        end
        do_reset();
        cfg.curve_en <= 1'b1;
        cfg.hc_trip <= 1'b1;
        meas_set.ph_a <= 16'h00C8;
        cyc(3*PER);
        meas_set.ph_a <= 16'h0032;
        cyc(PER);
        meas_set.ph_a <= 16'h00C8;
        wt("repeat overload sooner", gtp_pkg::TR_HC, 1'b1, 0, 2*PER+3);
        // earth fault acts only at curve expiry, as the configured action selects
        do_reset();
        cfg.ef_en <= 1'b1;
        cfg.ef_trip <= 1'b1;
        meas_set.earth <= 16'h0014;
        wt("earth trip", gtp_pkg::TR_EF, 1'b1, 3*PER-4, 4*PER+3);
        do_reset();
        cfg.prot_dis <= 1'b1;
        cfg.ef_en <= 1'b1;
        meas_set.earth <= 16'h0014;
        wt("earth inverse time", 10 + gtp_pkg::SD_EF, 1'b1, 3*PER-4, 4*PER+3);
        wt("alarm logged", 24, 1'b1, 0, 0);
        chk("still on load", 16'h0001, 16'(gen_close));
        chk("engine kept running", 16'h0000, 16'(eng_stop));
        chk("disabled shown", 16'h0001, 16'(stat.prot_dis_ind));
        do_reset();
        cfg.sc_en <= 1'b1;
        cfg.sc_trip <= 1'b1;
        meas_set.ph_a <= 16'h0190;
        wt("short circuit faster", gtp_pkg::TR_SC, 1'b1, PER-2, 2*PER+3);
        summarize();
    end
endmodule
